// *** src/pbs_consts.vh ***
// Purpose: Constants of the processor bus support logic.
// Assumes: Register bits are numbered with bit 0 as the most significant bit.
// Notes: Field macros give the Verilog index, that is 15 minus the bit number.
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH

`define PBS_CTRL_WR 16'h1f41
`define PBS_CTRL_RD 16'h9f41
`define PBS_FUO_WR 16'h1f47
`define PBS_FUO_RD 16'h9f47
`define PBS_FUI_WR 16'h1f48
`define PBS_FUI_RD 16'h9f48
`define PBS_FFA_RD 16'h9f49
`define PBS_STAT_RD 16'h9f4a
`define PBS_SYSCFG_RD 16'h8410
`define PBS_INTACK_WR 16'h1000
`define PBS_ROM_ON_WR 16'h5401
`define PBS_ROM_OFF_WR 16'h5400

`define PBS_SYS_LO 16'h1f40
`define PBS_SYS_HI 16'h1f4f
`define PBS_SYS_RD_LO 16'h9f40
`define PBS_SYS_RD_HI 16'h9f4f
`define PBS_SPARE_LO 16'h1f00
`define PBS_SPARE_HI 16'h1fff
`define PBS_SPARE_RD_LO 16'h9f00
`define PBS_SPARE_RD_HI 16'h9fff

`define PBS_UOUT_BASE 6'h00
`define PBS_UIN_BASE 6'h20

`define PBS_B_STROBE_FLOAT 10
`define PBS_B_ADDR_FLOAT 9
`define PBS_B_SPI 7
`define PBS_B_CORR_MODE 6
`define PBS_B_EIO 3
`define PBS_CTRL_MASK 16'h06c8
`define PBS_CTRL_RST 16'h0000

`define PBS_CMD_W 10
`define PBS_CMD_RST 10'h3ff
`define PBS_TEST_CYCLES 16

`endif

// *** src/pbs_bus_support.v ***
// Purpose: Address latch, strobe decode, I/O checks, correction support and system test.
// Assumes: All processor bus signals are synchronous to clk_sys.
// Notes: Registers are reached by processor I/O cycles on the multiplexed bus.
`timescale 1ns/1ns
`include "pbs_consts.vh"

// Summary of operation
// - Input command limit register, low ten bits.
// - Spare I/O flagged unless spare-legal bit set.
// - Latch bus address, hold from strobe fall.
// - With MMU, memory cycles drive low twelve.
// - I/O cycles drive all sixteen address bits.
// - Address bus floats on request when enabled.
// - Decode four strobes from strobe, direction, space.
// - Memory read held off while inhibit active.
// - Strobes float on request when enabled.
// - Correction bit swaps error pins' meaning.
// - Single error stalls ready, raises inhibit.
// - Single error drop ends stall and inhibit.
// - Failing address freezes on address error in normal mode until read.
// - Config word read enables or drives inputs.
// - Interrupt acknowledge pulse on its I/O write.
// - Boot ROM enable on at reset, commanded.
// - System test runs once when requested.
// - Test done output marks test completion or skip.
// - Status top bits report three test results.
// - User I/O beyond limits flags address error.
module pbs_bus_support #(
  parameter SYSCFG_DIRECT = 1'b1,
  parameter TEST_CYCLES = `PBS_TEST_CYCLES
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [15:0] muxed_info_bus_in,
  output wire [15:0] muxed_info_bus_out,
  output wire muxed_info_bus_oe,
  input wire address_strobe,
  input wire data_phase_strobe_n,
  input wire read_not_write,
  input wire memory_not_io,
  input wire float_request_n,
  input wire mmu_present,
  output wire [15:0] addr_bus_out,
  output wire [15:0] addr_bus_oe,
  input wire [1:0] addr_quarter_in,
  output wire memory_read_strobe_n,
  output wire memory_write_strobe_n,
  output wire io_read_strobe_n,
  output wire io_write_strobe_n,
  output wire strobes_oe,
  output wire parity_or_inhibit_out,
  output wire addr_err_or_single_out,
  output wire addr_err_or_single_oe,
  input wire addr_err_or_single_in,
  output wire data_ready,
  output wire sysconfig_enable_n,
  input wire [4:0] sysconfig_inputs,
  output wire int_acknowledge_pulse_n,
  output wire boot_rom_enable,
  input wire test_on_n,
  input wire cpu_test_pass,
  input wire mmu_test_pass,
  output wire test_done
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_DONE = 4'b0100;
  localparam ST_SKIP = 4'b1000;

  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  reg [15:0] addr_q;
  reg mem_cyc_q;
  reg astb_q;
  reg dstb_q;
  reg [15:0] ctrl_q;
  reg [`PBS_CMD_W-1:0] fuo_q;
  reg [`PBS_CMD_W-1:0] fui_q;
  reg [15:0] ffa_q;
  reg frozen_q;
  reg inhibit_q;
  reg boot_rom_q;
  reg [15:0] rd_data_q;
  reg rd_hit_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [15:0] tcnt_q;
  reg started_q;
  reg [2:0] result_q;
  reg own_ok_q;

  wire dstb = ~data_phase_strobe_n;
  wire io_cyc = ~mem_cyc_q;
  wire io_wr_take = dstb & ~dstb_q & io_cyc & ~read_not_write;
  wire io_rd = dstb & io_cyc & read_not_write;
  wire corr_mode = ctrl_q[`PBS_B_CORR_MODE];
  wire single_err = corr_mode & addr_err_or_single_in;
  wire is_sys = in_range(addr_q, `PBS_SYS_LO, `PBS_SYS_HI) |
    in_range(addr_q, `PBS_SYS_RD_LO, `PBS_SYS_RD_HI);
  wire is_spare = in_range(addr_q, `PBS_SPARE_LO, `PBS_SPARE_HI) |
    in_range(addr_q, `PBS_SPARE_RD_LO, `PBS_SPARE_RD_HI);
  wire spare_err = is_spare & ~is_sys & ~ctrl_q[`PBS_B_SPI];
  wire uout_err = (addr_q[15:10] == `PBS_UOUT_BASE) &
    (addr_q[`PBS_CMD_W-1:0] >= fuo_q);
  wire uin_err = (addr_q[15:10] == `PBS_UIN_BASE) &
    (addr_q[`PBS_CMD_W-1:0] >= fui_q);
  wire user_err = ctrl_q[`PBS_B_EIO] & (uout_err | uin_err);
  wire addr_err = dstb & io_cyc & (spare_err | user_err);
  wire float_now = ~float_request_n;

  // Address register loads the bus on each clock while the address strobe is high.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= 16'h0000;
      mem_cyc_q <= 1'b0;
      astb_q <= 1'b0;
      dstb_q <= 1'b0;
    end else begin
      astb_q <= address_strobe;
      dstb_q <= dstb;
      if (address_strobe) begin
        addr_q <= muxed_info_bus_in;
        mem_cyc_q <= memory_not_io;
      end
    end
  end

  // Address drivers: four top lines are inputs on mapped memory cycles.
  wire top_drive = ~(mmu_present & mem_cyc_q);
  wire addr_float = ctrl_q[`PBS_B_ADDR_FLOAT] & float_now;
  assign addr_bus_out = addr_q;
  assign addr_bus_oe = addr_float ? 16'h0000 :
    (top_drive ? 16'hffff : 16'h0fff);

  // Strobes are decoded from the live strobe so no clock of delay is added.
  assign memory_read_strobe_n = ~(dstb & mem_cyc_q & read_not_write & ~inhibit_q);
  assign memory_write_strobe_n = ~(dstb & mem_cyc_q & ~read_not_write);
  assign io_read_strobe_n = ~io_rd;
  assign io_write_strobe_n = ~(dstb & io_cyc & ~read_not_write);
  assign strobes_oe = ~(ctrl_q[`PBS_B_STROBE_FLOAT] & float_now);
  assign int_acknowledge_pulse_n =
    ~(dstb & io_cyc & ~read_not_write & (addr_q == `PBS_INTACK_WR));
  assign sysconfig_enable_n =
    ~(~SYSCFG_DIRECT & io_rd & (addr_q == `PBS_SYSCFG_RD));

  // Control and command registers, written by I/O writes.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `PBS_CTRL_RST;
      fuo_q <= `PBS_CMD_RST;
      fui_q <= `PBS_CMD_RST;
      boot_rom_q <= 1'b1;
    end else if (io_wr_take) begin
      case (addr_q)
        `PBS_CTRL_WR: ctrl_q <= muxed_info_bus_in & `PBS_CTRL_MASK;
        `PBS_FUO_WR: fuo_q <= muxed_info_bus_in[`PBS_CMD_W-1:0];
        `PBS_FUI_WR: fui_q <= muxed_info_bus_in[`PBS_CMD_W-1:0];
        `PBS_ROM_ON_WR: boot_rom_q <= 1'b1;
        `PBS_ROM_OFF_WR: boot_rom_q <= 1'b0;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
  assign boot_rom_enable = boot_rom_q;

  // Failing address: follows each strobe fall until an address error in normal mode freezes it.
  wire ffa_read = io_rd & ~dstb_q & (addr_q == `PBS_FFA_RD);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ffa_q <= 16'h0000;
      frozen_q <= 1'b0;
    end else begin
      if (astb_q & ~address_strobe & ~frozen_q) begin
        ffa_q <= addr_q;
      end
      if (addr_err & ~corr_mode) begin
        frozen_q <= 1'b1;
      end else if (ffa_read) begin
        frozen_q <= 1'b0;
      end
    end
  end

  // Error pins: address error out in normal mode, single error in with correction.
  assign addr_err_or_single_out = ~addr_err;
  assign addr_err_or_single_oe = ~corr_mode;
  assign parity_or_inhibit_out = corr_mode ? inhibit_q : 1'b0;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inhibit_q <= 1'b0;
    end else begin
      inhibit_q <= single_err;
    end
  end
  // Ready follows the single error line directly so the cycle ends as soon as it drops.
  assign data_ready = ~single_err;

  // Read data is prepared from the latched address before the data phase.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= 16'h0000;
      rd_hit_q <= 1'b0;
    end else begin
      rd_hit_q <= 1'b1;
      case (addr_q)
        `PBS_CTRL_RD: rd_data_q <= ctrl_q;
        `PBS_FUO_RD: rd_data_q <= {6'h00, fuo_q};
        `PBS_FUI_RD: rd_data_q <= {6'h00, fui_q};
        `PBS_FFA_RD: rd_data_q <= ffa_q;
        `PBS_STAT_RD: rd_data_q <= {result_q, 10'h000, addr_quarter_in, test_done};
        `PBS_SYSCFG_RD: begin
          rd_data_q <= {sysconfig_inputs, 11'h000};
          rd_hit_q <= SYSCFG_DIRECT;
        end
        default: begin
          rd_data_q <= 16'h0000;
          rd_hit_q <= 1'b0;
        end
      endcase
    end
  end
  assign muxed_info_bus_out = rd_data_q;
  assign muxed_info_bus_oe = io_rd & rd_hit_q;

  // System test sequencer: request sampled once after reset release.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = test_on_n ? ST_SKIP : ST_RUN;
      ST_RUN: begin
        if (tcnt_q == TEST_CYCLES[15:0] - 16'h0001) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_DONE;
      ST_SKIP: state_d = ST_SKIP;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      tcnt_q <= 16'h0000;
      started_q <= 1'b0;
      result_q <= 3'h0;
      own_ok_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_q == ST_RUN) begin
        started_q <= 1'b1;
        tcnt_q <= tcnt_q + 16'h0001;
        // Own check: the control register must still hold its reset value.
        if (ctrl_q != `PBS_CTRL_RST) begin
          own_ok_q <= 1'b0;
        end
        if (state_d == ST_DONE) begin
          result_q <= {cpu_test_pass, mmu_test_pass, own_ok_q};
        end
      end
    end
  end
  assign test_done = (state_q == ST_DONE) | (state_q == ST_SKIP);

endmodule // pbs_bus_support

// *** sim/pbs_bus_monitor.sv ***
// Purpose: Port checks of the bus support block.
// Assumes: Only top-level ports are seen.
// Notes: Attached by the bind below.
`timescale 1ns/1ns
module pbs_bus_monitor (
  input wire clk_sys,
  input wire arst_n,
  input wire [15:0] muxed_info_bus_in,
  input wire address_strobe,
  input wire data_phase_strobe_n,
  input wire read_not_write,
  input wire memory_not_io,
  input wire float_request_n,
  input wire mmu_present,
  input wire [15:0] addr_bus_out,
  input wire [15:0] addr_bus_oe,
  input wire memory_read_strobe_n,
  input wire io_write_strobe_n,
  input wire strobes_oe,
  input wire parity_or_inhibit_out,
  input wire addr_err_or_single_oe,
  input wire addr_err_or_single_in,
  input wire data_ready
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire se_on = !addr_err_or_single_oe && addr_err_or_single_in;
  wire se_off = !addr_err_or_single_oe && !addr_err_or_single_in;
  wire dp = !data_phase_strobe_n && float_request_n;
  sequence se_rise;
    se_off ##1 se_on;
  endsequence
  sequence se_fall;
    se_on ##1 se_off;
  endsequence
  latch_hold_a: assert property ($fell(address_strobe) |->
    addr_bus_out == $past(muxed_info_bus_in) ##1 $stable(addr_bus_out)) else $error("latch");
  io_addr_a: assert property (dp && !memory_not_io |-> addr_bus_oe == 16'hffff)
    else $error("io address width");
  mmu_addr_a: assert property (dp && memory_not_io && mmu_present |->
    addr_bus_oe == 16'h0fff) else $error("mmu address width");
  addr_float_a: assert property (addr_bus_oe == 16'h0 |-> !float_request_n)
    else $error("address float");
  strobe_float_a: assert property (!strobes_oe |-> !float_request_n)
    else $error("strobe float");
  iow_decode_a: assert property (io_write_strobe_n ==
    !(!data_phase_strobe_n && !read_not_write && !memory_not_io)) else $error("io write");
  memory_read_strobe_inhibit_a: assert property (parity_or_inhibit_out && !addr_err_or_single_oe
    |-> memory_read_strobe_n) else $error("read during inhibit");
  corr_start_a: assert property (se_rise |-> !data_ready ##1 parity_or_inhibit_out)
    else $error("correction start");
  corr_end_a: assert property (se_fall |-> data_ready ##1 !parity_or_inhibit_out)
    else $error("correction end");
endmodule // pbs_bus_monitor

bind pbs_bus_support pbs_bus_monitor pbs_bus_monitor_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .muxed_info_bus_in(muxed_info_bus_in),
  .address_strobe(address_strobe), .data_phase_strobe_n(data_phase_strobe_n),
  .read_not_write(read_not_write), .memory_not_io(memory_not_io),
  .float_request_n(float_request_n), .mmu_present(mmu_present),
  .addr_bus_out(addr_bus_out), .addr_bus_oe(addr_bus_oe),
  .memory_read_strobe_n(memory_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
  .strobes_oe(strobes_oe), .parity_or_inhibit_out(parity_or_inhibit_out),
  .addr_err_or_single_oe(addr_err_or_single_oe),
  .addr_err_or_single_in(addr_err_or_single_in), .data_ready(data_ready)
);

// *** sim/pbs_cpu_model.sv ***
// Purpose: Processor side of the bus.
// Assumes: One cycle at a time, launched by the bench.
// Notes: Released bus lines show the inverse of their last value.
`timescale 1ns/1ns
module pbs_cpu_model (
  input wire clk_sys,
  input wire [15:0] bus_out,
  input wire data_ready,
  input wire err_w,
  output reg [15:0] bus_q,
  output reg address_strobe,
  output reg data_phase_strobe_n,
  output reg read_not_write,
  output reg memory_not_io,
  output reg single_q
);
  initial begin
    bus_q = 16'h0;
    address_strobe = 1'b0;
    data_phase_strobe_n = 1'b1;
    read_not_write = 1'b1;
    memory_not_io = 1'b0;
    single_q = 1'b0;
  end
  task cyc(input m, input rw, input [15:0] ad, input [15:0] d, input [1:0] se,
    output [15:0] rd, output er);
    integer n;
    begin
      n = 0;
      @(posedge clk_sys);
      #1 address_strobe = 1'b1;
      bus_q = ad;
      memory_not_io = m;
      read_not_write = rw;
      @(posedge clk_sys);
      #1 address_strobe = 1'b0;
      bus_q = ~ad;
      @(posedge clk_sys);
      #1 data_phase_strobe_n = 1'b0;
      bus_q = rw ? ad : d;
      single_q = se != 2'd0;
      repeat (se) @(posedge clk_sys);
      if (se != 2'd0) #1 single_q = 1'b0;
      @(posedge clk_sys);
      while (!data_ready && n < 64) begin
        n = n + 1;
        @(posedge clk_sys);
      end
      rd = bus_out;
      er = err_w;
      #1 data_phase_strobe_n = 1'b1;
      bus_q = ~bus_q;
    end
  endtask
endmodule // pbs_cpu_model

// *** sim/pbs_bus_support_test.sv ***
// Purpose: Self-checking bench of the bus support block.
// Assumes: Cycles come from pbs_cpu_model.
// Notes: Random values come from an xorshift generator.
`timescale 1ns/1ns
`include "pbs_consts.vh"
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, g, x); end end
module pbs_bus_support_test;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg float_request_n = 1'b1;
  reg mmu_present = 1'b0;
  reg test_on_n = 1'b0;
  reg [4:0] sysconfig_inputs = 5'h0;
  reg [31:0] seed = 32'h79f9a9d3;
  integer mismatches = 0, checks = 0, acks = 0, i;
  reg [15:0] r, v, a;
  reg e;
  wire [15:0] bus_q, bus_out, bus_w, addr_bus_oe;
  wire address_strobe, data_phase_strobe_n, read_not_write, memory_not_io, single_q;
  wire bus_oe, strobes_oe, err_out, err_oe, err_w, data_ready, ack_n, boot_rom_enable, test_done;
  assign bus_w = bus_oe ? bus_out : bus_q;
  assign err_w = err_oe ? err_out : single_q;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (!ack_n) acks++;
  pbs_bus_support pbs_bus_support_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .muxed_info_bus_in(bus_w),
    .muxed_info_bus_out(bus_out), .muxed_info_bus_oe(bus_oe),
    .address_strobe(address_strobe), .data_phase_strobe_n(data_phase_strobe_n),
    .read_not_write(read_not_write), .memory_not_io(memory_not_io),
    .float_request_n(float_request_n), .mmu_present(mmu_present),
    .addr_bus_out(), .addr_bus_oe(addr_bus_oe), .addr_quarter_in(2'b10),
    .memory_read_strobe_n(), .memory_write_strobe_n(), .io_read_strobe_n(),
    .io_write_strobe_n(), .strobes_oe(strobes_oe), .parity_or_inhibit_out(),
    .addr_err_or_single_out(err_out), .addr_err_or_single_oe(err_oe),
    .addr_err_or_single_in(err_w), .data_ready(data_ready), .sysconfig_enable_n(),
    .sysconfig_inputs(sysconfig_inputs), .int_acknowledge_pulse_n(ack_n),
    .boot_rom_enable(boot_rom_enable), .test_on_n(test_on_n),
    .cpu_test_pass(1'b1), .mmu_test_pass(1'b0), .test_done(test_done));
  pbs_cpu_model pbs_cpu_model_inst (
    .clk_sys(clk_sys), .bus_out(bus_out), .data_ready(data_ready), .err_w(err_w),
    .bus_q(bus_q), .address_strobe(address_strobe), .data_phase_strobe_n(data_phase_strobe_n),
    .read_not_write(read_not_write), .memory_not_io(memory_not_io), .single_q(single_q));
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function uerr(input [15:0] x, input [9:0] lim);
    return x[15:10] == 6'h20 && x[9:0] >= lim;
  endfunction
  task io(input rw, input [15:0] ad, input [15:0] d);
    pbs_cpu_model_inst.cyc(1'b0, rw, ad, d, 2'd0, r, e);
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    for (i = 0; i < 200 && test_done !== 1'b1; i++) @(posedge clk_sys);
    #1 test_on_n = 1'b1;
    `CHK(test_done, 1'b1)
    io(1'b1, `PBS_STAT_RD, 16'h0);
    `CHK({r[15:13], r[0]}, 4'hb)
    `CHK(boot_rom_enable, 1'b1)
    io(1'b0, `PBS_ROM_OFF_WR, 16'h0);
    `CHK(boot_rom_enable, 1'b0)
    io(1'b0, `PBS_ROM_ON_WR, 16'h0);
    `CHK(boot_rom_enable, 1'b1)
    io(1'b0, `PBS_INTACK_WR, 16'h0);
    `CHK(acks, 1)
    v = rnd();
    sysconfig_inputs = v[4:0];
    io(1'b1, `PBS_SYSCFG_RD, 16'h0);
    `CHK(r[15:11], sysconfig_inputs)
    $display("test decode done");
    io(1'b1, `PBS_FUI_RD, 16'h0);
    `CHK(r[9:0], `PBS_CMD_RST)
    io(1'b0, `PBS_FUI_WR, v);
    io(1'b1, `PBS_FUI_RD, 16'h0);
    `CHK(r[9:0], v[9:0])
    io(1'b0, 16'h1f20, 16'h0);
    `CHK(e, 1'b0)
    io(1'b1, 16'h9f4b, 16'h0);
    `CHK(e, 1'b1)
    io(1'b1, `PBS_FFA_RD, 16'h0);
    `CHK(r, 16'h1f20)
    io(1'b0, `PBS_CTRL_WR, 16'h1 << `PBS_B_SPI | 16'h1 << `PBS_B_EIO);
    io(1'b0, 16'h1f20, 16'h0);
    `CHK(e, 1'b1)
    for (i = 0; i < 12; i++) begin
      r = rnd();
      a = {6'h20, v[9:0] + r[1:0] - 10'd2};
      io(1'b1, a, 16'h0);
      `CHK(e, !uerr(a, v[9:0]))
    end
    $display("test registers done");
    io(1'b0, `PBS_CTRL_WR, 16'h1 << `PBS_B_STROBE_FLOAT | 16'h1 << `PBS_B_ADDR_FLOAT);
    float_request_n = 1'b0;
    @(posedge clk_sys);
    #1 `CHK(addr_bus_oe, 16'h0)
    `CHK(strobes_oe, 1'b0)
    float_request_n = 1'b1;
    $display("test float done");
    io(1'b0, `PBS_CTRL_WR, 16'h1 << `PBS_B_CORR_MODE);
    `CHK(err_oe, 1'b0)
    for (i = 0; i < 30; i++) begin
      v = rnd();
      a = rnd();
      mmu_present = v[0];
      test_on_n = v[1];
      pbs_cpu_model_inst.cyc(1'b1, v[2], a, v, v[2] ? v[5:4] : 2'd0, r, e);
      `CHK(data_ready, 1'b1)
    end
    `CHK(test_done, 1'b1)
    $display("test correction done");
    results();
  end
endmodule // pbs_bus_support_test
